// ==== hw/hrs_stack.v ====
// Hardware return-address stack with APB register access.
// Assumes a core sequencer that pulses push and pop for one cycle each,
// and a reset controller that acts on the stack reset request pulse.
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "hrs_consts.vh"

// Behaviour
// - Sixteen entries of fifteen bits hold saved program counter values.
// - Storage is reachable only through these ports, not program or data space.
// - Call, call via working register, or interrupt vectoring pushes the PC.
// - Return, return with literal, return from interrupt pops the stack.
// - Push and pop leave the PC upper latch untouched.
// - With overflow reset disabled the stack wraps; seventeenth push overwrites first.
// - Overflow and underflow set their flags whether or not reset is enabled.
// - Writing the index selects an entry; top registers read and write it.
// - Index is five bits; range beyond sixteen detects overflow and underflow.
// - Push increments index then writes; pop reads entry then decrements.
// - Index always shows the entry in use, readable any time.
// - After reset the stack is empty with index 0x1F.
// - Empty with overflow reset enabled: top registers read zero.
// - Empty with overflow reset disabled: top registers read entry 0x0E.
module hrs_stack #(
  parameter DEPTH = `HRS_DEPTH,
  parameter PC_W  = `HRS_PC_W
) (
  // Clock and reset
  input  wire              core_clk,
  input  wire              nrst,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // Core sequencer
  input  wire              push_req,
  input  wire [PC_W-1:0]   push_pc,
  input  wire              pop_req,
  output reg  [PC_W-1:0]   pop_pc_r,
  output reg               pop_valid_r,
  // System
  output reg               stack_reset_r,
  output reg               irq_r
);

  // ****************************************************************
  // State
  // ****************************************************************
  reg [PC_W-1:0]          entry_r [0:DEPTH-1];
  reg [`HRS_PTR_W-1:0]    stack_index_reg_r;
  reg [`HRS_PTR_W-1:0]    stack_index_reg_nxt;
  reg                     overflow_reset_enable_r;
  reg                     overflow_flag_r;
  reg                     underflow_flag_r;
  reg [`HRS_ST_W-1:0]     mask_r;
  reg                     overflow_ev;
  reg                     underflow_ev;
  reg                     push_wr;
  reg [3:0]               push_slot;
  reg [PC_W-1:0]          top_value;
  reg                     top_writable;
  reg [3:0]               top_slot;
  reg [31:0]              rd_data;
  reg                     addr_ok;
  reg                     ovf_nxt;
  reg                     unf_nxt;
  reg [PC_W-1:0]          top_wr_value;
  reg [DEPTH-1:0]         entry_we;
  integer                 i;

  wire                    apb_setup;
  wire                    apb_done;
  wire                    apb_wr;
  wire                    apb_rd;
  wire                    index_empty;
  wire                    sel_index;
  wire                    sel_top_low;
  wire                    sel_top_high;
  wire                    sel_config;
  wire                    sel_status;
  wire                    sel_mask;
  wire                    sw_top_wr;

  assign apb_setup   = psel & penable & ~pready;
  assign apb_done    = psel & penable & pready;
  assign apb_wr      = apb_done & pwrite & ~pslverr;
  assign apb_rd      = apb_done & ~pwrite & ~pslverr;
  assign index_empty = (stack_index_reg_r == `HRS_PTR_RST);

  // Register selects for the write strobes and the status read clear; the read mux decodes paddr itself
  assign sel_index    = (paddr == `HRS_OFF_INDEX);
  assign sel_top_low  = (paddr == `HRS_OFF_TOP_LOW);
  assign sel_top_high = (paddr == `HRS_OFF_TOP_HIGH);
  assign sel_config   = (paddr == `HRS_OFF_CONFIG);
  assign sel_status   = (paddr == `HRS_OFF_STATUS);
  assign sel_mask     = (paddr == `HRS_OFF_MASK);
  // Software top writes yield to any core operation in the same cycle
  assign sw_top_wr    = apb_wr & top_writable & ~push_req & ~pop_req &
                        (sel_top_low | sel_top_high);

  // ****************************************************************
  // Top-of-stack view
  // ****************************************************************
  always @*
  begin
    top_slot     = stack_index_reg_r[3:0];
    top_writable = 1'b1;
    top_value    = entry_r[stack_index_reg_r[3:0]];
    if (index_empty)
    begin
      if (overflow_reset_enable_r)
      begin
        top_value    = {PC_W{1'b0}};
        top_writable = 1'b0;
      end
      else
      begin
        top_slot  = `HRS_EMPTY_ENTRY;
        top_value = entry_r[`HRS_EMPTY_ENTRY];
      end
    end
  end

  // ****************************************************************
  // Push and pop sequencing
  // ****************************************************************
  // Core operations win over a software index write in the same cycle;
  // a lost push would corrupt the return chain.
  always @*
  begin
    stack_index_reg_nxt = stack_index_reg_r;
    overflow_ev         = 1'b0;
    underflow_ev        = 1'b0;
    push_wr             = 1'b0;
    push_slot           = 4'h0;
    if (push_req)
    begin
      if (stack_index_reg_r == `HRS_PTR_TOP)
      begin
        overflow_ev = 1'b1;
        if (overflow_reset_enable_r)
          stack_index_reg_nxt = `HRS_PTR_OVF;
        else
        begin
          stack_index_reg_nxt = {`HRS_PTR_W{1'b0}};
          push_wr             = 1'b1;
        end
      end
      else
      begin
        stack_index_reg_nxt = stack_index_reg_r + 5'h01;
        push_wr             = 1'b1;
      end
      push_slot = stack_index_reg_nxt[3:0];
    end
    else if (pop_req)
    begin
      if (index_empty)
      begin
        underflow_ev = 1'b1;
        if (!overflow_reset_enable_r)
          stack_index_reg_nxt = `HRS_UNF_PTR;
      end
      else
        stack_index_reg_nxt = stack_index_reg_r - 5'h01;
    end
    else if (apb_wr && sel_index)
      stack_index_reg_nxt = pwdata[`HRS_PTR_W-1:0];
  end

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      stack_index_reg_r <= `HRS_PTR_RST;
    else
      stack_index_reg_r <= stack_index_reg_nxt;
  end

  // ****************************************************************
  // Entry storage
  // ****************************************************************
  always @*
  begin
    top_wr_value = top_value;
    if (sel_top_low)
      top_wr_value[`HRS_LOW_W-1:0] = pwdata[`HRS_LOW_W-1:0];
    else
      top_wr_value[PC_W-1:`HRS_LOW_W] = pwdata[`HRS_HIGH_W-1:0];
  end

  // One write enable per entry; a push always beats a software write
  always @*
  begin
    entry_we = {DEPTH{1'b0}};
    if (push_wr)
      entry_we[push_slot] = 1'b1;
    else if (sw_top_wr)
      entry_we[top_slot] = 1'b1;
  end

  // Entries are not cleared by reset; with overflow reset enabled the empty index hides them.
  always @(posedge core_clk)
  begin
    for (i = 0; i < DEPTH; i = i + 1)
    begin
      if (entry_we[i])
        entry_r[i] <= push_wr ? push_pc : top_wr_value;
    end
  end

  // Popped PC is read before the index moves; upper latch is not here.
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pop_pc_r    <= {PC_W{1'b0}};
      pop_valid_r <= 1'b0;
    end
    else
    begin
      pop_valid_r <= pop_req & ~push_req;
      if (pop_req && !push_req)
        pop_pc_r <= top_value;
    end
  end

  // ****************************************************************
  // Flags, mask, interrupt and reset request
  // ****************************************************************
  always @*
  begin
    ovf_nxt = overflow_flag_r;
    unf_nxt = underflow_flag_r;
    if (apb_rd && sel_status)
    begin
      ovf_nxt = 1'b0;
      unf_nxt = 1'b0;
    end
    if (overflow_ev)
      ovf_nxt = 1'b1;
    if (underflow_ev)
      unf_nxt = 1'b1;
  end

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      overflow_flag_r  <= 1'b0;
      underflow_flag_r <= 1'b0;
    end
    else
    begin
      overflow_flag_r  <= ovf_nxt;
      underflow_flag_r <= unf_nxt;
    end
  end

  // Mask and overflow reset enable are plain software registers
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mask_r                  <= `HRS_MASK_RST;
      overflow_reset_enable_r <= `HRS_CFG_RST;
    end
    else
    begin
      if (apb_wr && sel_mask)
        mask_r <= pwdata[`HRS_ST_W-1:0];
      if (apb_wr && sel_config)
        overflow_reset_enable_r <= pwdata[`HRS_CFG_OVRST_BIT];
    end
  end

  // Interrupt follows the flags as they will stand after this edge
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_r         <= 1'b0;
      stack_reset_r <= 1'b0;
    end
    else
    begin
      irq_r         <= |({unf_nxt, ovf_nxt} & mask_r);
      stack_reset_r <= overflow_reset_enable_r & (overflow_ev | underflow_ev);
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  always @*
  begin
    addr_ok = 1'b1;
    rd_data = `HRS_ZERO32;
    case (paddr)
      `HRS_OFF_INDEX:
        rd_data[`HRS_PTR_W-1:0] = stack_index_reg_r;
      `HRS_OFF_TOP_LOW:
        rd_data[`HRS_LOW_W-1:0] = top_value[`HRS_LOW_W-1:0];
      `HRS_OFF_TOP_HIGH:
        rd_data[`HRS_HIGH_W-1:0] = top_value[PC_W-1:`HRS_LOW_W];
      `HRS_OFF_CONFIG:
        rd_data[`HRS_CFG_OVRST_BIT] = overflow_reset_enable_r;
      `HRS_OFF_STATUS:
        rd_data[`HRS_ST_W-1:0] = {underflow_flag_r, overflow_flag_r};
      `HRS_OFF_MASK:
        rd_data[`HRS_ST_W-1:0] = mask_r;
      default:
        addr_ok = 1'b0;
    endcase
  end

  // One wait state: pready rises the cycle after the first access cycle,
  // so data is sampled one edge after it is captured.
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready  <= 1'b0;
      prdata  <= `HRS_ZERO32;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= apb_setup;
      if (apb_setup)
      begin
        pslverr <= ~addr_ok;
        prdata  <= (pwrite || !addr_ok) ? `HRS_ZERO32 : rd_data;
      end
      else
      begin
        pslverr <= 1'b0;
        prdata  <= `HRS_ZERO32;
      end
    end
  end

endmodule // hrs_stack
`default_nettype wire

// ==== include/hrs_consts.vh ====
// Constants of the hardware return stack: register offsets, fields,
// reset values and stack geometry.
// Assumes inclusion by bare name from the design files.
`ifndef HRS_CONSTS_VH
`define HRS_CONSTS_VH

// ****************************************************************
// Stack geometry
// ****************************************************************
`define HRS_DEPTH          16
`define HRS_PC_W           15
`define HRS_PTR_W          5
`define HRS_PTR_RST        5'h1f
`define HRS_PTR_TOP        5'h0f
`define HRS_PTR_OVF        5'h10
`define HRS_EMPTY_ENTRY    4'he
`define HRS_UNF_PTR        5'h0e

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define HRS_ADDR_W         12
`define HRS_OFF_INDEX      12'h000
`define HRS_OFF_TOP_LOW    12'h004
`define HRS_OFF_TOP_HIGH   12'h008
`define HRS_OFF_CONFIG     12'h00c
`define HRS_OFF_STATUS     12'h010
`define HRS_OFF_MASK       12'h014

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define HRS_LOW_W          8
`define HRS_HIGH_W         7
`define HRS_CFG_OVRST_BIT  0
`define HRS_ST_OVF_BIT     0
`define HRS_ST_UNF_BIT     1
`define HRS_ST_W           2
`define HRS_CFG_RST        1'b1
`define HRS_MASK_RST       2'h0
`define HRS_ZERO32         32'h0000_0000

`endif

// ==== verif/hrs_stack_asserts.sv ====
// Port checker for the return stack, bound to hrs_stack.
// Assumes one clock domain with asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module hrs_stack_chk (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Core side
  input wire logic        push_req,
  input wire logic        pop_req,
  input wire logic        pop_valid_r,
  input wire logic        stack_reset_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_WAIT_STATE: assert property ((psel && !penable ##1 psel && penable) |=> pready)
    else $error("pready not in second access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  AST_UNMAPPED_ERR: assert property (pready && paddr > 12'h014 |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (pready && paddr[1:0] == 2'b00 && paddr <= 12'h014 |-> !pslverr)
    else $error("mapped access refused");
  AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside completion");
  AST_POP_ANSWER: assert property (pop_req && !push_req |=> pop_valid_r)
    else $error("pop not answered next cycle");
  AST_POP_ONLY: assert property (!(pop_req && !push_req) |=> !pop_valid_r)
    else $error("pop answer without a pop");
  AST_RST_CAUSE: assert property (stack_reset_r |-> $past(push_req || pop_req))
    else $error("stack reset request without push or pop");
  AST_RST_PULSE: assert property (stack_reset_r |=> !stack_reset_r)
    else $error("stack reset request too long");
  cover property (pop_valid_r);
  cover property (stack_reset_r);
  cover property (pslverr);
endmodule // hrs_stack_chk
bind hrs_stack hrs_stack_chk u_chk (.core_clk(core_clk), .nrst(nrst), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .push_req(push_req), .pop_req(pop_req), .pop_valid_r(pop_valid_r),
  .stack_reset_r(stack_reset_r));
`default_nettype wire

// ==== verif/hrs_core_model.sv ====
// Core sequencer model: calls push, returns pop.
// Assumes tasks are called from the bench, one at a time.
`timescale 1ns/1ps
`default_nettype none
module hrs_core_model (
  // Clock
  input wire logic         core_clk,
  // Stack requests
  output var logic         push_req,
  output var logic [14:0]  push_pc,
  output var logic         pop_req
);
  initial
  begin
    push_req = 1'b0;
    push_pc = 15'h0000;
    pop_req = 1'b0;
  end
  // Back-to-back calls, one per cycle
  task automatic call_burst(input int cnt, input logic [14:0] base);
    @(posedge core_clk);
    for (int k = 0; k < cnt; k++)
    begin
      push_req <= 1'b1;
      push_pc <= base + k[14:0];
      @(posedge core_clk);
    end
    push_req <= 1'b0;
    // Stale PC inverted so no one relies on it
    push_pc <= ~push_pc;
  endtask
  task automatic ret_op;
    @(posedge core_clk);
    pop_req <= 1'b1;
    @(posedge core_clk);
    pop_req <= 1'b0;
  endtask
endmodule // hrs_core_model
`default_nettype wire

// ==== verif/hardware_return_stack_tb_top.sv ====
// Bench for the return stack: APB tasks and a core model.
// Assumes hrs_stack, its checker and hrs_core_model are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "hrs_consts.vh"
module hardware_return_stack_tb_top;
  logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr, rerr;
  logic        push_req, pop_req, pop_valid_r, stack_reset_r, irq_r;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [14:0] push_pc, pop_pc_r;
  int          n_fail = 0;
  int          n_checks = 0;
  localparam logic [11:0] IDX = `HRS_OFF_INDEX, TL = `HRS_OFF_TOP_LOW, TH = `HRS_OFF_TOP_HIGH;
  localparam logic [11:0] CFG = `HRS_OFF_CONFIG, ST = `HRS_OFF_STATUS, MSK = `HRS_OFF_MASK;
  hrs_stack u_dut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .push_req(push_req), .push_pc(push_pc), .pop_req(pop_req),
    .pop_pc_r(pop_pc_r), .pop_valid_r(pop_valid_r), .stack_reset_r(stack_reset_r),
    .irq_r(irq_r));
  hrs_core_model u_core (.core_clk(core_clk), .push_req(push_req), .push_pc(push_pc),
    .pop_req(pop_req));
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Idle cycle first, so a strobe is never set twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1 && ++n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      n_fail++;
      tally_and_finish;
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask
  initial
  begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    rd(IDX, 32'h0000_001f);
    rd(TL, 32'h0000_0000);
    rd(TH, 32'h0000_0000);
    $display("Test reset done");
    u_core.call_burst(3, 15'h7a50);
    rd(IDX, 32'h0000_0002);
    apb(1'b1, IDX, 32'h0000_0000);
    rd(TL, 32'h0000_0050);
    rd(TH, 32'h0000_007a);
    apb(1'b1, TH, 32'h0000_0011);
    rd(TH, 32'h0000_0011);
    apb(1'b1, IDX, 32'h0000_0002);
    u_core.ret_op;
    #1 chk({pop_valid_r, pop_pc_r}, 32'h0000_fa52);
    rd(IDX, 32'h0000_0001);
    $display("Test push pop done");
    apb(1'b1, CFG, 32'h0000_0000);
    apb(1'b1, MSK, 32'h0000_0003);
    apb(1'b1, IDX, 32'h0000_001f);
    u_core.call_burst(17, 15'h0100);
    rd(IDX, 32'h0000_0000);
    rd(TL, 32'h0000_0010);
    chk(irq_r, 1'b1);
    rd(ST, 32'h0000_0001);
    rd(ST, 32'h0000_0000);
    chk(irq_r, 1'b0);
    apb(1'b1, IDX, 32'h0000_001f);
    rd(TL, 32'h0000_000e);
    u_core.ret_op;
    #1 chk(pop_pc_r, 32'h0000_010e);
    rd(IDX, 32'h0000_000e);
    rd(ST, 32'h0000_0002);
    $display("Test wrap done");
    apb(1'b1, CFG, 32'h0000_0001);
    apb(1'b1, MSK, 32'h0000_0000);
    apb(1'b1, IDX, 32'h0000_000f);
    u_core.call_burst(1, 15'h0123);
    #1 chk(stack_reset_r, 1'b1);
    rd(IDX, 32'h0000_0010);
    chk(irq_r, 1'b0);
    rd(ST, 32'h0000_0001);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    chk({31'h0000_0000, rerr}, 32'h0000_0001);
    $display("Test overflow reset done");
    tally_and_finish;
  end
endmodule // hardware_return_stack_tb_top
`default_nettype wire
